// ### rtl/isbe_slave.sv
// isbe_slave: i2c slave engine with apb register access
// assumes: an i2c master on the bus, software on apb, no wait states
`timescale 1ns/100ps
`include "isbe_regs.svh"
module isbe_slave (
  input wire logic pclk,          // system clock, 50 MHz
  input wire logic presetn,       // async reset, active low
  input wire logic psel,          // apb select
  input wire logic penable,       // apb access phase
  input wire logic pwrite,        // apb direction, 1 write
  input wire logic [11:0] paddr,  // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata,     // apb read data
  output logic pready,            // apb ready, always high
  output logic pslverr,           // apb error on unmapped address
  output logic i2c_irq,           // one-cycle interrupt request
  isbe_if.dev bus                 // i2c bus side
);
  isbe_pkg::isbe_dev_state_e state_reg;
  isbe_pkg::isbe_byte_t data_reg, sh_reg;
  logic [6:0] own_addr_reg;
  logic [3:0] cnt_reg;
  logic [2:0] mode_reg;
  logic en_reg, tx_ack_reg, tx_sel_reg, own_bit0_reg;
  logic busy_reg, match_reg, rw_reg, rx_ack_reg, sda_low_reg, scl_low_reg;
  logic scl_s, sda_s, scl_d, sda_d, scl_rise, scl_fall;
  logic start_det, stop_det, active, release_evt, rx_done;
  logic wr_acc, rd_acc, data_wr, data_rd;
  // true when the apb address selects the given register
  function automatic logic reg_hit(input logic [11:0] a,
                                   input logic [11:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit
  // line synchronisers and one extra stage for edge finding
  isbe_sync u_scl_sync (.pclk(pclk), .presetn(presetn), .din(bus.scl),
    .dout(scl_s));
  isbe_sync u_sda_sync (.pclk(pclk), .presetn(presetn), .din(bus.sda),
    .dout(sda_s));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scl_d, sda_d} <= 2'b11;
    end else begin
      {scl_d, sda_d} <= {scl_s, sda_s};
    end
  end
  // bus events
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s;
  assign active = en_reg && (mode_reg == `ISBE_MODE_I2C);

  // apb strobes; access phase is the single effective edge
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign data_wr = wr_acc && reg_hit(paddr, `ISBE_DATA_OFS);
  assign data_rd = rd_acc && reg_hit(paddr, `ISBE_DATA_OFS);
  assign pready = 1'b1;
  assign pslverr = psel && penable &&
    !(reg_hit(paddr, `ISBE_CTRL_OFS) || reg_hit(paddr, `ISBE_STAT_OFS) ||
      reg_hit(paddr, `ISBE_ADDR_OFS) || reg_hit(paddr, `ISBE_DATA_OFS));

  // software access to the data register frees a held scl: a write when tx_sel_reg is set, a read when it is clear
  assign release_evt = (state_reg == isbe_pkg::DS_HOLD) &&
    ((tx_sel_reg && data_wr) || (!tx_sel_reg && data_rd));
  assign rx_done = (state_reg == isbe_pkg::DS_RX) && scl_rise &&
    (cnt_reg == 4'h7);
  // control registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= `ISBE_MODE_RST;
      en_reg <= 1'b0;
      tx_ack_reg <= 1'b0;
      tx_sel_reg <= 1'b0;
      own_addr_reg <= 7'h00;
      own_bit0_reg <= 1'b0;
    end else if (wr_acc) begin
      if (reg_hit(paddr, `ISBE_CTRL_OFS)) begin
        mode_reg <= pwdata[`ISBE_MODE_MSB:`ISBE_MODE_LSB];
        en_reg <= pwdata[`ISBE_EN_BIT];
      end
      if (reg_hit(paddr, `ISBE_STAT_OFS)) begin
        tx_ack_reg <= pwdata[`ISBE_TX_ACK_BIT];
        tx_sel_reg <= pwdata[`ISBE_TXSEL_BIT];
      end
      if (reg_hit(paddr, `ISBE_ADDR_OFS)) begin
        own_addr_reg <= pwdata[`ISBE_OWN_MSB:`ISBE_OWN_LSB];
        own_bit0_reg <= pwdata[0];
      end
    end
  end
  // shared data register: received byte wins over a same-cycle write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) data_reg <= 8'h00;
    else if (rx_done) data_reg <= {sh_reg[6:0], sda_s};
    else if (data_wr) data_reg <= pwdata[7:0];
  end
  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (reg_hit(paddr, `ISBE_CTRL_OFS)) begin
        prdata[`ISBE_MODE_MSB:`ISBE_MODE_LSB] <= mode_reg;
        prdata[`ISBE_EN_BIT] <= en_reg;
      end
      if (reg_hit(paddr, `ISBE_STAT_OFS)) begin
        prdata[`ISBE_RX_ACK_BIT] <= rx_ack_reg;
        prdata[`ISBE_RW_BIT] <= rw_reg;
        prdata[`ISBE_TX_ACK_BIT] <= tx_ack_reg;
        prdata[`ISBE_TXSEL_BIT] <= tx_sel_reg;
        prdata[`ISBE_BUSY_BIT] <= busy_reg;
        prdata[`ISBE_MATCH_BIT] <= match_reg;
      end
      if (reg_hit(paddr, `ISBE_ADDR_OFS)) begin
        prdata[7:0] <= {own_addr_reg, own_bit0_reg};
      end
      if (reg_hit(paddr, `ISBE_DATA_OFS)) prdata[7:0] <= data_reg;
    end
  end
  // bus busy tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_reg <= 1'b0;
    else if (start_det) busy_reg <= 1'b1;
    else if (stop_det) busy_reg <= 1'b0;
  end

  // bit engine: address, acknowledge, hold, data bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= isbe_pkg::DS_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      sda_low_reg <= 1'b0;
      match_reg <= 1'b0;
      rw_reg <= 1'b0;
      rx_ack_reg <= 1'b0;
      i2c_irq <= 1'b0;
    end else begin
      i2c_irq <= 1'b0;
      if (!active || stop_det) begin
        state_reg <= isbe_pkg::DS_IDLE;
        sda_low_reg <= 1'b0;
      end else if (start_det) begin
        state_reg <= isbe_pkg::DS_ADDR;
        cnt_reg <= 4'h0;
        sda_low_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          isbe_pkg::DS_IDLE, isbe_pkg::DS_WAIT_STOP: begin
            sda_low_reg <= 1'b0;
          end
          isbe_pkg::DS_ADDR: begin
            if (scl_rise) begin
              if (cnt_reg == 4'h7) begin
                if (sh_reg[6:0] == own_addr_reg) begin
                  rw_reg <= sda_s;
                  match_reg <= 1'b1;
                  state_reg <= isbe_pkg::DS_ADDR_ACK;
                end else begin
                  state_reg <= isbe_pkg::DS_WAIT_STOP;
                end
              end else begin
                sh_reg <= {sh_reg[6:0], sda_s};
                cnt_reg <= cnt_reg + 4'h1;
              end
            end
          end
          isbe_pkg::DS_ADDR_ACK: begin
            if (scl_fall) begin
              if (!sda_low_reg) begin
                sda_low_reg <= 1'b1;
              end else begin
                sda_low_reg <= 1'b0;
                state_reg <= isbe_pkg::DS_HOLD;
                i2c_irq <= 1'b1;
              end
            end
          end
          isbe_pkg::DS_HOLD: begin
            if (release_evt) begin
              cnt_reg <= 4'h0;
              if (tx_sel_reg) begin
                sh_reg <= pwdata[7:0];
                sda_low_reg <= !pwdata[7];
                state_reg <= isbe_pkg::DS_TX;
              end else begin
                state_reg <= isbe_pkg::DS_RX;
              end
            end
          end
          isbe_pkg::DS_TX: begin
            if (scl_fall) begin
              if (cnt_reg == 4'h7) begin
                sda_low_reg <= 1'b0;
                state_reg <= isbe_pkg::DS_ACK;
              end else begin
                sh_reg <= {sh_reg[6:0], 1'b0};
                sda_low_reg <= !sh_reg[6];
                cnt_reg <= cnt_reg + 4'h1;
              end
            end
          end
          isbe_pkg::DS_RX: begin
            if (scl_rise && cnt_reg != 4'h8) begin
              sh_reg <= {sh_reg[6:0], sda_s};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == 4'h8) begin
              sda_low_reg <= !tx_ack_reg;
              state_reg <= isbe_pkg::DS_ACK;
            end
          end
          isbe_pkg::DS_ACK: begin
            if (scl_rise && tx_sel_reg) begin
              rx_ack_reg <= sda_s;
            end
            if (scl_fall) begin
              sda_low_reg <= 1'b0;
              match_reg <= 1'b0;
              i2c_irq <= 1'b1;
              if (tx_sel_reg && rx_ack_reg) begin
                state_reg <= isbe_pkg::DS_WAIT_STOP;
              end else begin
                state_reg <= isbe_pkg::DS_HOLD;
              end
            end
          end
        endcase
      end
    end
  end

  // scl stretch follows the hold state one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_low_reg <= 1'b0;
    end else begin
      scl_low_reg <= active && (state_reg == isbe_pkg::DS_HOLD);
    end
  end

  // open-drain drivers
  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_scl_oe_n = !scl_low_reg;
  assign bus.dev_sda_oe_n = !sda_low_reg;
endmodule : isbe_slave

// ### inc/isbe_regs.svh
// isbe_regs.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the design modules and the testbench
`ifndef ISBE_REGS_SVH
`define ISBE_REGS_SVH

// apb byte offsets of the slave's registers
`define ISBE_CTRL_OFS 12'h000
`define ISBE_STAT_OFS 12'h004
`define ISBE_ADDR_OFS 12'h008
`define ISBE_DATA_OFS 12'h00c

// serial_control_reg fields
`define ISBE_MODE_MSB 7
`define ISBE_MODE_LSB 5
`define ISBE_EN_BIT 1
`define ISBE_MODE_I2C 3'h6
`define ISBE_MODE_RST 3'h7

// slave_control_reg fields
`define ISBE_RX_ACK_BIT 0
`define ISBE_RW_BIT 2
`define ISBE_TX_ACK_BIT 3
`define ISBE_TXSEL_BIT 4
`define ISBE_BUSY_BIT 5
`define ISBE_MATCH_BIT 6

// own_address_reg field
`define ISBE_OWN_MSB 7
`define ISBE_OWN_LSB 1

// timing of the master's generated scl
`define ISBE_SYS_PERIOD_NS 20
`define ISBE_SCL_PERIOD_NS 400
`define ISBE_HALF_CYC (`ISBE_SCL_PERIOD_NS / `ISBE_SYS_PERIOD_NS / 2)
`define ISBE_SDA_SETUP_CYC (`ISBE_HALF_CYC / 2)

`endif

// ### inc/isbe_pkg.sv
// isbe_pkg: types shared by both ends of the i2c slave engine
// assumes: isbe_regs.svh holds every number
package isbe_pkg;

  // slave bit engine states
  typedef enum logic [2:0] {
    DS_IDLE, DS_ADDR, DS_ADDR_ACK, DS_HOLD, DS_TX, DS_RX, DS_ACK, DS_WAIT_STOP
  } isbe_dev_state_e;

  // master sequencer states
  typedef enum logic [2:0] {
    HS_IDLE, HS_START, HS_LOW, HS_HIGH, HS_STOP1, HS_STOP2, HS_STOP3
  } isbe_host_state_e;

  typedef logic [7:0] isbe_byte_t;
  typedef logic [4:0] isbe_tmr_t;

endpackage : isbe_pkg

// ### inc/isbe_if.sv
// isbe_if: the two-wire bus between master and slave
// assumes: open-drain drivers with active-low enables, pull-ups modelled here
`timescale 1ns/100ps
interface isbe_if;
  logic dev_scl_o;
  logic dev_scl_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic scl;
  logic sda;

  // wired-and with pull-up: low when any enabled driver pulls low
  assign scl = !((!dev_scl_oe_n && !dev_scl_o) ||
                 (!host_scl_oe_n && !host_scl_o));
  assign sda = !((!dev_sda_oe_n && !dev_sda_o) ||
                 (!host_sda_oe_n && !host_sda_o));

  modport dev (input scl, input sda, output dev_scl_o, output dev_scl_oe_n,
               output dev_sda_o, output dev_sda_oe_n);
  modport host (input scl, input sda, output host_scl_o,
                output host_scl_oe_n, output host_sda_o,
                output host_sda_oe_n);
endinterface : isbe_if

// ### rtl/isbe_sync.sv
// isbe_sync: two flip-flop synchroniser for one bus line
// assumes: din is asynchronous to pclk; idles high like a pulled-up line
`timescale 1ns/100ps
module isbe_sync (
  input wire logic pclk,    // system clock
  input wire logic presetn, // async reset, active low
  input wire logic din,     // asynchronous line
  output logic dout         // synchronised level
);
  logic meta_reg;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : isbe_sync

// ### rtl/isbe_master.sv
// isbe_master: single-byte i2c master that drives the slave engine
// assumes: bus idle at each command; scl made here from pclk by a divider
`timescale 1ns/100ps
`include "isbe_regs.svh"
module isbe_master (
  input wire logic pclk,            // system clock, 50 MHz
  input wire logic presetn,         // async reset, active low
  input wire logic cmd_valid,       // start one transaction
  output logic cmd_ready,           // idle, command accepted
  input wire logic [6:0] cmd_addr,  // slave address
  input wire logic cmd_rw,          // 1 read, 0 write
  input wire logic [7:0] cmd_wdata, // byte to write
  output logic rsp_done,            // one-cycle pulse at end
  output logic rsp_nack,            // the address or the written byte was not acknowledged
  output logic [7:0] rsp_rdata,     // byte read
  isbe_if.host bus                  // i2c bus side
);
  isbe_pkg::isbe_host_state_e state_reg;
  isbe_pkg::isbe_tmr_t tmr_reg;
  logic [8:0] tx_reg;
  logic [7:0] rx_reg;
  logic [3:0] bit_reg;
  logic byte1_reg;
  logic rw_reg;
  logic [7:0] wdata_reg;
  logic scl_low_reg;
  logic sda_low_reg;
  logic scl_s;
  logic sda_s;

  isbe_sync u_scl_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(bus.scl),
    .dout(scl_s)
  );
  isbe_sync u_sda_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(bus.sda),
    .dout(sda_s)
  );

  assign cmd_ready = (state_reg == isbe_pkg::HS_IDLE);

  // sequencer: start, 9-bit address frame, 9-bit data frame only if the address is acked, stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= isbe_pkg::HS_IDLE;
      tmr_reg <= 5'h00;
      tx_reg <= 9'h1ff;
      rx_reg <= 8'h00;
      bit_reg <= 4'h0;
      byte1_reg <= 1'b0;
      rw_reg <= 1'b0;
      wdata_reg <= 8'h00;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      rsp_done <= 1'b0;
      rsp_nack <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_done <= 1'b0;
      if (tmr_reg != 5'h00) begin
        tmr_reg <= tmr_reg - 5'h01;
      end
      unique case (state_reg)
        isbe_pkg::HS_IDLE: begin
          if (cmd_valid) begin
            sda_low_reg <= 1'b1;
            tx_reg <= {cmd_addr, cmd_rw, 1'b1};
            rw_reg <= cmd_rw;
            wdata_reg <= cmd_wdata;
            bit_reg <= 4'h0;
            byte1_reg <= 1'b0;
            rsp_nack <= 1'b0;
            tmr_reg <= 5'(`ISBE_HALF_CYC);
            state_reg <= isbe_pkg::HS_START;
          end
        end
        isbe_pkg::HS_START: begin
          if (tmr_reg == 5'h00) begin
            scl_low_reg <= 1'b1;
            tmr_reg <= 5'(`ISBE_HALF_CYC);
            state_reg <= isbe_pkg::HS_LOW;
          end
        end
        isbe_pkg::HS_LOW: begin
          if (tmr_reg == 5'(`ISBE_SDA_SETUP_CYC)) begin
            sda_low_reg <= !tx_reg[8];
          end
          if (tmr_reg == 5'h00) begin
            scl_low_reg <= 1'b0;
            tmr_reg <= 5'(`ISBE_HALF_CYC);
            state_reg <= isbe_pkg::HS_HIGH;
          end
        end
        isbe_pkg::HS_HIGH: begin
          if (!scl_s) begin
            tmr_reg <= 5'(`ISBE_HALF_CYC);
          end else if (tmr_reg == 5'h00) begin
            rx_reg <= {rx_reg[6:0], sda_s};
            scl_low_reg <= 1'b1;
            tmr_reg <= 5'(`ISBE_HALF_CYC);
            if (bit_reg != 4'h8) begin
              tx_reg <= {tx_reg[7:0], 1'b1};
              bit_reg <= bit_reg + 4'h1;
              state_reg <= isbe_pkg::HS_LOW;
            end else if (!byte1_reg && !sda_s) begin
              byte1_reg <= 1'b1;
              bit_reg <= 4'h0;
              tx_reg <= rw_reg ? 9'h1ff : {wdata_reg, 1'b1};
              state_reg <= isbe_pkg::HS_LOW;
            end else begin
              rsp_nack <= byte1_reg ? (sda_s && !rw_reg) : sda_s;
              rsp_rdata <= rx_reg[7:0];
              state_reg <= isbe_pkg::HS_STOP1;
            end
          end
        end
        isbe_pkg::HS_STOP1: begin
          if (tmr_reg == 5'(`ISBE_SDA_SETUP_CYC)) begin
            sda_low_reg <= 1'b1;
          end
          if (tmr_reg == 5'h00) begin
            scl_low_reg <= 1'b0;
            tmr_reg <= 5'(`ISBE_HALF_CYC);
            state_reg <= isbe_pkg::HS_STOP2;
          end
        end
        isbe_pkg::HS_STOP2: begin
          if (!scl_s) begin
            tmr_reg <= 5'(`ISBE_HALF_CYC);
          end else if (tmr_reg == 5'h00) begin
            sda_low_reg <= 1'b0;
            tmr_reg <= 5'(`ISBE_HALF_CYC);
            state_reg <= isbe_pkg::HS_STOP3;
          end
        end
        isbe_pkg::HS_STOP3: begin
          if (tmr_reg == 5'h00) begin
            rsp_done <= 1'b1;
            state_reg <= isbe_pkg::HS_IDLE;
          end
        end
      endcase
    end
  end

  // open-drain drivers
  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe_n = !scl_low_reg;
  assign bus.host_sda_oe_n = !sda_low_reg;
endmodule : isbe_master

// ### bench/isbe_monitor.sv
// isbe_monitor: wire-level checks on the bus joining master and slave
// assumes: instantiated beside isbe_if, fed its signals by name
`timescale 1ns/100ps
module isbe_monitor (
  input wire logic pclk,          // system clock
  input wire logic presetn,       // async reset, active low
  input wire logic scl,           // resolved clock line
  input wire logic sda,           // resolved data line
  input wire logic dev_scl_oe_n,  // slave pulls scl when low
  input wire logic dev_sda_oe_n,  // slave pulls sda when low
  input wire logic host_scl_oe_n, // master pulls scl when low
  input wire logic host_sda_oe_n  // master pulls sda when low
);
  default clocking mcb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // slave data changes only while the clock line is low
  property p_sda_moves_low; $changed(dev_sda_oe_n) |-> !scl; endproperty
  a_sda_moves_low: assert property (p_sda_moves_low)
    else $error("slave moved sda while scl high");
  // a start on the wire always comes from the master
  property p_start_by_host;
    $fell(sda) && scl && $past(scl) |-> !host_sda_oe_n;
  endproperty
  a_start_by_host: assert property (p_start_by_host)
    else $error("start not made by master");
  // the slave only begins a stretch on an already low clock
  property p_stretch_on_low; $fell(dev_scl_oe_n) |-> !$past(scl); endproperty
  a_stretch_on_low: assert property (p_stretch_on_low)
    else $error("slave stretch began with scl high");
  // after a stretch ends, data stays put for 8 cycles of the high phase
  property p_hold_after_release;
    $rose(dev_scl_oe_n) |=> $stable(dev_sda_oe_n)[*8];
  endproperty
  a_hold_after_release: assert property (p_hold_after_release)
    else $error("slave sda moved after stretch release");
  // slave keeps its data a while after each clock fall
  property p_sda_hold_after_fall;
    $fell(scl) |-> $stable(dev_sda_oe_n)[*2];
  endproperty
  a_sda_hold_after_fall: assert property (p_sda_hold_after_fall)
    else $error("slave sda changed too soon after scl fall");
  // a stop can only be made with the slave off the data line
  property p_stop_sda_free;
    $rose(sda) && scl && $past(scl) |-> dev_sda_oe_n;
  endproperty
  a_stop_sda_free: assert property (p_stop_sda_free)
    else $error("slave held sda at stop");
  // after a stop the slave leaves both lines alone
  property p_idle_after_stop;
    $rose(sda) && scl && $past(scl) |-> (dev_sda_oe_n && dev_scl_oe_n)[*8];
  endproperty
  a_idle_after_stop: assert property (p_idle_after_stop)
    else $error("slave drove bus after stop");
  // the slave listens, never drives, right after a start
  property p_quiet_after_start;
    $fell(sda) && scl && $past(scl) |-> dev_sda_oe_n[*8];
  endproperty
  a_quiet_after_start: assert property (p_quiet_after_start)
    else $error("slave drove sda after start");
endmodule : isbe_monitor

// ### bench/i2c_slave_bus_engine_tb.sv
// i2c_slave_bus_engine_tb: master and slave ends joined on one bus
// assumes: package, interface, both ends and monitor compiled before
`timescale 1ns/100ps
`include "isbe_regs.svh"
module i2c_slave_bus_engine_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, i2c_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic cmd_valid, cmd_ready, cmd_rw, rsp_done, rsp_nack;
  logic [6:0] cmd_addr, own;
  logic [7:0] cmd_wdata, rsp_rdata;
  logic [31:0] q_exp[$], q_msk[$], r_exp[$], r_msk[$];
  logic [31:0] cfg[3] = '{32'h02, 32'hc0, 32'he2};
  int num_errors = 0;
  int cmp_count = 0;
  isbe_if bus_if ();

  isbe_slave isbe_slave_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i2c_irq(i2c_irq), .bus(bus_if.dev));
  isbe_master isbe_master_i (.pclk(pclk), .presetn(presetn),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr),
    .cmd_rw(cmd_rw), .cmd_wdata(cmd_wdata), .rsp_done(rsp_done),
    .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata), .bus(bus_if.host));
  isbe_monitor isbe_monitor_i (.pclk(pclk), .presetn(presetn),
    .scl(bus_if.scl), .sda(bus_if.sda), .dev_scl_oe_n(bus_if.dev_scl_oe_n),
    .dev_sda_oe_n(bus_if.dev_sda_oe_n),
    .host_scl_oe_n(bus_if.host_scl_oe_n),
    .host_sda_oe_n(bus_if.host_sda_oe_n));

  // system clock, 20 ns period
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, exp, msk);
    cmp_count++;
    if ((got & msk) !== (exp & msk)) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got & msk, exp & msk);
    end
  endtask : chk

  task automatic close_out();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // one apb transfer; for reads d is the expected word under mask m
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, m);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) begin
      r_exp.push_back(d);
      r_msk.push_back(m);
    end
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk({31'h0, pslverr}, {31'h0, a > 12'h00c}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one master command; e is the expected {nack, rdata} under mask m
  task automatic xfer(input logic [6:0] a, input logic rw,
                      input logic [7:0] d, input logic [8:0] e, m);
    q_exp.push_back({23'h0, e});
    q_msk.push_back({23'h0, m});
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd_addr <= a;
    cmd_rw <= rw;
    cmd_wdata <= d;
    do @(posedge pclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do @(posedge pclk); while (rsp_done !== 1'b1);
  endtask : xfer

  task automatic wait_irq();
    do @(posedge pclk); while (i2c_irq !== 1'b1);
  endtask : wait_irq

  // slave software for a master write, answering with ack value ak
  task automatic sw_rx(input logic [7:0] d, input logic ak);
    wait_irq();
    apb(0, `ISBE_STAT_OFS, 32'h60, 32'h64);
    apb(1, `ISBE_STAT_OFS, {28'h0, ak, 3'h0}, 0);
    apb(0, `ISBE_DATA_OFS, 0, 0);
    wait_irq();
    apb(0, `ISBE_STAT_OFS, 32'h20, 32'h60);
    apb(0, `ISBE_DATA_OFS, {24'h0, d}, 32'hff);
  endtask : sw_rx

  // slave software for a master read of byte t
  task automatic sw_tx(input logic [7:0] t);
    wait_irq();
    apb(0, `ISBE_STAT_OFS, 32'h64, 32'h64);
    apb(1, `ISBE_STAT_OFS, 32'h10, 0);
    apb(1, `ISBE_DATA_OFS, {24'h0, t}, 0);
    wait_irq();
    apb(0, `ISBE_STAT_OFS, 32'h01, 32'h41);
  endtask : sw_tx

  // results are matched to the oldest note as they appear
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready && r_exp.size() > 0)
      chk(prdata, r_exp.pop_front(), r_msk.pop_front());
    if (rsp_done === 1'b1 && q_exp.size() > 0)
      chk({23'h0, rsp_nack, rsp_rdata}, q_exp.pop_front(),
          q_msk.pop_front());
  end

  // watchdog cuts a hang short
  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    close_out();
  end

  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {cmd_valid, cmd_addr, cmd_rw, cmd_wdata} = '0;
    seed = 32'h3163d42e;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(0, `ISBE_CTRL_OFS, 32'he0, 32'hff);
    apb(0, `ISBE_STAT_OFS, 0, 32'h7d);
    apb(0, 12'h010, 0, 32'hffffffff);
    seed = lfsr(seed);
    own = seed[6:0];
    apb(1, `ISBE_ADDR_OFS, {24'h0, own, 1'b1}, 0);
    apb(0, `ISBE_ADDR_OFS, {24'h0, own, 1'b1}, 32'hff);
    // no answer unless mode 110 and enabled
    for (int i = 0; i < 3; i++) begin
      apb(1, `ISBE_CTRL_OFS, cfg[i], 0);
      xfer(own, 1'b0, 8'h00, 9'h100, 9'h100);
    end
    apb(1, `ISBE_CTRL_OFS, 32'hc2, 0);
    for (int k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      fork
        xfer(own, 1'b0, seed[7:0], {k[0], 8'h0}, 9'h100);
        sw_rx(seed[7:0], k[0]);
      join
    end
    seed = lfsr(seed);
    fork
      xfer(own, 1'b1, 8'h00, {1'b0, seed[7:0]}, 9'h0ff);
      sw_tx(seed[7:0]);
    join
    xfer(own ^ 7'h01, 1'b0, 8'h5a, 9'h100, 9'h100);
    apb(0, `ISBE_STAT_OFS, 0, 32'h60);
    close_out();
  end
endmodule : i2c_slave_bus_engine_tb
